/* verilog/ocd_top.sv */
// Notes on behaviour
// - Period is mark plus one plus space plus one
// - Each count is four bits, zero to fifteen
// - High time equals mark plus one cycles
// - Space in bits 7:4, mark in 3:0
// - Both zero gives two-cycle period, half high
// - Period four allows quarter, half, three quarters
// - Mark and space honoured independently
// - Duty choices are whole-cycle splits of period
//
// Added by the designer: register access over AHB-Lite.
`timescale 1ns/1ps
`include "ocd_consts.svh"
module ocd_top
  import ocd_pkg::*;
(
  input wire logic CLK,
  input wire logic RST,
  input wire logic HSEL,
  input wire logic [31:0] HADDR,
  input wire logic [1:0] HTRANS,
  input wire logic HWRITE,
  input wire logic [2:0] HSIZE,
  input wire logic [31:0] HWDATA,
  input wire logic HREADY,
  output logic [31:0] HRDATA,
  output logic HREADYOUT,
  output logic HRESP,
  output logic DIV_OUT
);
  // Divider configuration register
  ocd_byte_t div_q;
  ocd_byte_t div_d;
  // Pending write to the divider register
  logic wr_q;
  logic wr_d;
  // Registered read data
  logic [31:0] rdata_q;
  logic [31:0] rdata_d;
  // Decoded address phase
  logic acc;
  logic hit_div;
  logic hit_stat;
  // Counter fields and state
  ocd_nib_t mark_field;
  ocd_nib_t space_field;
  logic level;
  ocd_nib_t cnt;
  // Byte forwarded from a write in its data phase
  ocd_byte_t div_fwd;

  // Address phase decode; only valid transfers when bus is ready
  always_comb
  begin
    acc = HSEL && HREADY && HTRANS[1];
    hit_div = (HADDR[31:10] == `OCD_ADDR_HI_ZERO) && (HADDR[9:2] == `OCD_IDX_DIV);
    hit_stat = (HADDR[31:10] == `OCD_ADDR_HI_ZERO) && (HADDR[9:2] == `OCD_IDX_STAT);
  end

  // Field split of the divider register
  always_comb
  begin
    mark_field = div_q[`OCD_MARK_MSB:`OCD_MARK_LSB];
    space_field = div_q[`OCD_SPACE_MSB:`OCD_SPACE_LSB];
  end

  // Next register values and read data
  always_comb
  begin
    wr_d = acc && HWRITE && hit_div;
    div_d = div_q;
    // Data phase of a write stores the low byte
    if (wr_q)
    begin
      div_d = HWDATA[7:0];
    end
    div_fwd = wr_q ? HWDATA[7:0] : div_q;
    rdata_d = rdata_q;
    if (acc && !HWRITE)
    begin
      rdata_d = `OCD_RDATA_RST;
      if (hit_div)
      begin
        // Newest value, even right after a write
        rdata_d[7:0] = div_fwd;
      end
      else if (hit_stat)
      begin
        // Live output level and phase count
        rdata_d[`OCD_STAT_LVL] = level;
        rdata_d[`OCD_STAT_CNT_MSB:`OCD_STAT_CNT_LSB] = cnt;
      end
    end
  end

  // Bus-side registers
  always_ff @(posedge CLK or posedge RST)
  begin
    if (RST)
    begin
      div_q <= `OCD_DIV_RST;
      wr_q <= 1'b0;
      rdata_q <= `OCD_RDATA_RST;
      HREADYOUT <= `OCD_HREADY_RST;
      HRESP <= `OCD_HRESP_OKAY;
    end
    else
    begin
      div_q <= div_d;
      wr_q <= wr_d;
      rdata_q <= rdata_d;
      // Zero wait states, always OKAY
      HREADYOUT <= `OCD_HREADY_RST;
      HRESP <= `OCD_HRESP_OKAY;
    end
  end

  // Read data and output both come from flops
  always_comb
  begin
    HRDATA = rdata_q;
    DIV_OUT = level;
  end

  // Mark/space counter on the bus clock CLK
  ocd_counter u_counter (
    .clk(CLK),
    .rst(RST),
    .mark_field(mark_field),
    .space_field(space_field),
    .level_q(level),
    .cnt_q(cnt)
  );

  // Helper: cycles since the last rising edge of the output
  logic [5:0] per_q;
  logic [5:0] per_d;
  logic cfg_ok_q;
  logic cfg_ok_d;
  logic lvl_prev_q;
  logic rise;
  always_comb
  begin
    rise = level && !lvl_prev_q;
    per_d = rise ? 6'h00 : per_q + 6'h01;
    // A write landing on the rising cycle spoils the coming period too
    cfg_ok_d = rise ? !wr_q : (cfg_ok_q && !wr_q);
  end
  always_ff @(posedge CLK or posedge RST)
  begin
    if (RST)
    begin
      per_q <= 6'h00;
      cfg_ok_q <= 1'b0;
      lvl_prev_q <= 1'b1;
    end
    else
    begin
      per_q <= per_d;
      cfg_ok_q <= cfg_ok_d;
      lvl_prev_q <= level;
    end
  end

  a_period_len: assert property (@(posedge CLK) disable iff (RST)
    rise && cfg_ok_q && !wr_q |-> per_q == ({2'b00, mark_field} + {2'b00, space_field} + 6'h01))
    else $error("Output period differs from mark plus space plus two");
  a_duty_split: assert property (@(posedge CLK) disable iff (RST)
    level && $stable(mark_field) |-> cnt <= mark_field) else $error("High phase longer than mark count");
  a_low_bound: assert property (@(posedge CLK) disable iff (RST)
    !level && $stable(space_field) |-> cnt <= space_field) else $error("Low phase longer than space count");
  a_write_store: assert property (@(posedge CLK) disable iff (RST)
    wr_q |=> div_q == $past(HWDATA[7:0])) else $error("Divider write not stored");
  a_read_back: assert property (@(posedge CLK) disable iff (RST)
    acc && !HWRITE && hit_div && !wr_q |=> HRDATA[7:0] == div_q && HRDATA[31:8] == 24'h000000)
    else $error("Divider read-back wrong");
  a_bus_okay: assert property (@(posedge CLK) disable iff (RST)
    HREADYOUT && !HRESP) else $error("Slave not ready or not OKAY");
endmodule : ocd_top

/* verilog/ocd_consts.svh */
`ifndef OCD_CONSTS_SVH
`define OCD_CONSTS_SVH
// Register indices; byte address is four times the index
`define OCD_IDX_DIV 8'h4a
`define OCD_IDX_STAT 8'h4b
// Divider register reset value: both counts zero
`define OCD_DIV_RST 8'h00
// Field positions inside the divider register
`define OCD_MARK_LSB 0
`define OCD_MARK_MSB 3
`define OCD_SPACE_LSB 4
`define OCD_SPACE_MSB 7
// Status register field positions
`define OCD_STAT_LVL 0
`define OCD_STAT_CNT_LSB 4
`define OCD_STAT_CNT_MSB 7
// Count value at the start of every phase, and the step added each cycle
`define OCD_CNT_ZERO 4'h0
`define OCD_CNT_ONE 4'h1
// Upper address bits that must be zero for a hit
`define OCD_ADDR_HI_ZERO 22'h000000
// Bus answer constants
`define OCD_HRESP_OKAY 1'b0
`define OCD_HREADY_RST 1'b1
`define OCD_RDATA_RST 32'h00000000
`endif

/* verilog/ocd_pkg.sv */
package ocd_pkg;
  // One 4-bit count field
  typedef logic [3:0] ocd_nib_t;
  // One register byte
  typedef logic [7:0] ocd_byte_t;
endpackage : ocd_pkg

/* verilog/ocd_counter.sv */
`timescale 1ns/1ps
`include "ocd_consts.svh"
module ocd_counter
  import ocd_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input ocd_pkg::ocd_nib_t mark_field,
  input ocd_pkg::ocd_nib_t space_field,
  output logic level_q,
  output ocd_pkg::ocd_nib_t cnt_q
);
  logic level_d; // Next output level
  ocd_nib_t cnt_d; // Next count within phase

  // Next state: high for mark+1 cycles, low for space+1, no gaps
  always_comb
  begin
    level_d = level_q;
    cnt_d = cnt_q + `OCD_CNT_ONE;
    if (level_q && (cnt_q >= mark_field))
    begin
      // End of high phase
      level_d = 1'b0;
      cnt_d = `OCD_CNT_ZERO;
    end
    else if (!level_q && (cnt_q >= space_field))
    begin
      // End of low phase
      level_d = 1'b1;
      cnt_d = `OCD_CNT_ZERO;
    end
  end

  // Registers only
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      level_q <= 1'b1;
      cnt_q <= `OCD_CNT_ZERO;
    end
    else
    begin
      level_q <= level_d;
      cnt_q <= cnt_d;
    end
  end

  // Last cycle of high phase
  sequence s_high_end;
    level_q && (cnt_q == mark_field);
  endsequence
  // Last cycle of low phase
  sequence s_low_end;
    !level_q && (cnt_q == space_field);
  endsequence
  // First cycle of either phase
  sequence s_phase_start;
    cnt_q == `OCD_CNT_ZERO;
  endsequence

  a_fall_at_mark: assert property (@(posedge clk) disable iff (rst)
    (!rst) ##0 s_high_end |=> !level_q ##0 s_phase_start) else $error("High phase did not end at mark count");
  a_rise_at_space: assert property (@(posedge clk) disable iff (rst)
    s_low_end |=> level_q ##0 s_phase_start) else $error("Low phase did not end at space count");
  a_high_count_up: assert property (@(posedge clk) disable iff (rst)
    level_q && (cnt_q < mark_field) |=> level_q && (cnt_q == $past(cnt_q) + `OCD_CNT_ONE))
    else $error("High phase count did not advance");
  a_low_count_up: assert property (@(posedge clk) disable iff (rst)
    !level_q && (cnt_q < space_field) |=> !level_q && (cnt_q == $past(cnt_q) + `OCD_CNT_ONE))
    else $error("Low phase count did not advance");
  a_div2_toggle: assert property (@(posedge clk) disable iff (rst)
    !rst && (mark_field == `OCD_CNT_ZERO) && (space_field == `OCD_CNT_ZERO) ##1
    (mark_field == `OCD_CNT_ZERO) && (space_field == `OCD_CNT_ZERO) |-> level_q != $past(level_q))
    else $error("Divide by two does not toggle every cycle");
  a_high_width: assert property (@(posedge clk) disable iff (rst)
    $rose(level_q) && (mark_field == `OCD_CNT_ONE) ##1 (mark_field == `OCD_CNT_ONE) |-> level_q ##1 !level_q)
    else $error("High time of two cycles not kept");
endmodule : ocd_counter

/* verif/ocd_top_bench.sv */
`timescale 1ns/1ps
`include "ocd_consts.svh"
module ocd_top_bench;
  import ocd_pkg::*;
  // Block ports
  logic CLK, RST, HSEL, HWRITE, HREADY, HREADYOUT, HRESP, DIV_OUT;
  logic [31:0] HADDR, HWDATA, HRDATA;
  logic [1:0] HTRANS;
  logic [2:0] HSIZE;
  // Counters and run tracking
  int mismatches, tests_run, cyc, run, hi_len;
  logic [31:0] exp_q[$]; // Expected read words
  logic rd_ph, chk_en, lvl;
  ocd_nib_t em, es; // Fields now programmed
  logic [7:0] tbl[9] = '{8'h00, 8'h11, 8'h02, 8'h20, 8'h42, 8'h24, 8'hff, 8'h0f, 8'hf0};
  localparam logic [31:0] DIV_A = {`OCD_ADDR_HI_ZERO, `OCD_IDX_DIV, 2'b00};
  localparam logic [31:0] STAT_A = {`OCD_ADDR_HI_ZERO, `OCD_IDX_STAT, 2'b00};
  // One slave: its ready is the bus ready
  assign HREADY = HREADYOUT;

  ocd_top u_ocd_top (.CLK(CLK), .RST(RST), .HSEL(HSEL), .HADDR(HADDR), .HTRANS(HTRANS), .HWRITE(HWRITE),
    .HSIZE(HSIZE), .HWDATA(HWDATA), .HREADY(HREADY), .HRDATA(HRDATA), .HREADYOUT(HREADYOUT),
    .HRESP(HRESP), .DIV_OUT(DIV_OUT));

  // Clock, 100 ns period
  initial
  begin
    CLK = 1'b0;
    forever #50 CLK = ~CLK;
  end

  // Compare and count
  task ck(input logic [31:0] seen, input logic [31:0] exp, input string m);
    tests_run++;
    if (seen !== exp)
    begin
      mismatches++;
      $display("wrong value at %0t: %s seen %h expected %h", $time, m, seen, exp);
    end
  endtask : ck

  // Verdict and end of run
  task close_out;
    $display("counts: %0d compared, %0d wrong", tests_run, mismatches);
    if (mismatches == 0 && tests_run > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : close_out

  // Single AHB transfer, entered just after a rising edge
  task bus(input logic w, input logic [31:0] a, input logic [31:0] d);
    HSEL <= 1'b1;
    HADDR <= a;
    HTRANS <= 2'b10;
    HWRITE <= w;
    do @(posedge CLK); while (HREADYOUT !== 1'b1);
    HSEL <= 1'b0;
    HTRANS <= 2'b00;
    HWDATA <= d;
    rd_ph <= !w;
    do @(posedge CLK); while (HREADYOUT !== 1'b1);
    rd_ph <= 1'b0;
  endtask : bus

  // Read with a note of the expected word
  task rd(input logic [31:0] a, input logic [31:0] e);
    exp_q.push_back(e);
    bus(1'b0, a, 32'h00000000);
  endtask : rd

  // Hang guard
  always @(posedge CLK)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      mismatches++;
      close_out;
    end
  end

  // Read watcher: oldest note against data phase word
  always @(posedge CLK)
    if (rd_ph === 1'b1)
    begin
      ck(HRDATA, exp_q.pop_front(), "read");
      ck(32'(HRESP), 32'(`OCD_HRESP_OKAY), "response");
    end

  // Output watcher: length of each high and low run
  always @(posedge CLK)
    if (RST)
    begin
      run = 0;
      lvl = 1'b1;
    end
    else if (DIV_OUT !== lvl)
    begin
      // Run just ended: high run or low run
      if (chk_en && lvl)
        ck(32'(run), 32'(em) + 1, "high run");
      if (chk_en && !lvl)
        ck(32'(run), 32'(es) + 1, "low run");
      if (chk_en && !lvl)
        ck(32'(run + hi_len), 32'(em) + 32'(es) + 2, "period");
      if (lvl)
        hi_len = run;
      run = 1;
      lvl = DIV_OUT;
    end
    else
      run++;

  // Main sequence
  initial
  begin
    logic [7:0] v;
    HSEL = 1'b0;
    HADDR = 32'h00000000;
    HTRANS = 2'b00;
    HWRITE = 1'b0;
    HSIZE = 3'h2;
    HWDATA = 32'h00000000;
    rd_ph = 1'b0;
    chk_en = 1'b0;
    em = 4'h0;
    es = 4'h0;
    RST = 1'b1;
    void'($urandom(89601));
    repeat (5) @(posedge CLK);
    RST <= 1'b0;
    @(posedge CLK);
    // Status at divide by two: third cycle after release is high, count zero
    @(posedge CLK);
    rd(STAT_A, 32'h00000001);
    // Reset value, unmapped read, unmapped write ignored
    rd(DIV_A, {24'h000000, `OCD_DIV_RST});
    rd(32'h00000000, 32'h00000000);
    bus(1'b1, 32'h00000000, 32'h000000ff);
    rd(DIV_A, 32'h00000000);
    $display("test register map done");
    // Each pair: write, read back, then measure runs
    for (int i = 0; i < 10; i++)
    begin
      v = (i < 9) ? tbl[i] : 8'($urandom);
      chk_en <= 1'b0;
      bus(1'b1, DIV_A, {24'hffffff, v});
      rd(DIV_A, {24'h000000, v});
      em <= v[3:0];
      es <= v[7:4];
      repeat (70) @(posedge CLK);
      chk_en <= 1'b1;
      repeat (100) @(posedge CLK);
      $display("test divider %h done", v);
    end
    chk_en <= 1'b0;
    @(posedge CLK);
    close_out;
  end
endmodule : ocd_top_bench
